//--- rtl/debug_core.sv
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
// Contract
// R1 - All messages pass through send queue
// R2 - External variant: fetch from instruction register
// R3 - External variant: halt while register empty
// R4 - Monitor variant: fetch program memory, ignore register
// R5 - Step: run one instruction, re-enter debug
// R6 - Comparators match address, optionally value
// R7 - Comparators use virtual addresses
// R8 - Break hit forces debug mode
// R9 - Watch hit sends message, no halt
// R10 - Watch hit starts or stops trace
// R11 - Comparators chain into compound condition
// R12 - Branch messages only on flow change
// R13 - Relative addresses plus periodic sync
// R14 - Data trace reads, writes or both
// R15 - Overflow halts CPU or sends error+sync
// R16 - Owner register write sends owner message
// R17 - Event pin toggles per queued message
// R18 - Memory unit uses physical addresses
// R19 - Tool translates addresses before transfers
// R20 - CPU pushes data to tool unasked
// R21 - Indexed registers from emulator and CPU
// R22 - Emulator commands via JTAG, trace via aux; commands arrive over APB here
// R23 - Queue delivers in insertion order
module debug_core
  import dbg_pkg::*;
#(
  parameter int NCMP = 4,
  parameter int DEPTH = 16,
  parameter int LANES = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB (debugger register path)
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU move-to/from debug register port
  input wire logic cpu_reg_wr,
  input wire logic [7:0] cpu_reg_addr,
  input wire logic [31:0] cpu_reg_wdata,
  output logic [31:0] cpu_reg_rdata,
  // CPU fetch and access observation (virtual addresses)
  input wire logic cpu_fetch,
  input wire logic [31:0] cpu_pc,
  input wire dbg_pkg::branch_kind_t cpu_branch,
  input wire logic [31:0] cpu_target,
  input wire logic cpu_dacc,
  input wire logic cpu_dwrite,
  input wire logic [31:0] cpu_daddr,
  input wire logic [31:0] cpu_dvalue,
  input wire logic cpu_retd,
  input wire logic cpu_inst_taken,
  input wire logic cpu_push,
  input wire logic [31:0] cpu_push_data,
  // CPU control
  output logic cpu_halt,
  output logic cpu_debug,
  output logic cpu_fetch_dbg,
  output logic cpu_fetch_monitor,
  output logic [31:0] dbg_inst,
  output logic dbg_inst_valid,
  // Physical memory port
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_paddr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Aux link and event pin
  input wire logic aux_clk,
  output logic [LANES-1:0] aux_data,
  output logic aux_frame,
  output logic event_out_pin
);
  typedef enum logic [1:0] {RUN, DEBUG, STEP_RUN} flow_t;

  flow_t flow_q;
  logic [31:0] ctrl_q, owner_q, mem_addr_q, mem_data_q;
  logic [31:0] inst_q;
  logic inst_full_q, mem_busy_q, mem_we_q, trace_on_q, ovf_q, err_pend_q, sync_pend_q;
  logic [31:0] cmp_addr_q [NCMP];
  logic [31:0] cmp_val_q [NCMP];
  logic [7:0] cmp_cfg_q [NCMP];
  logic [31:0] last_pc_q, last_da_q;
  logic [$clog2(SYNC_PERIOD)-1:0] sync_cnt_q;

  // ==========================================================
  // Register access: APB from emulator side, move port from CPU
  wire apb_wr = psel && penable && pwrite; // R22
  wire [7:0] wa = apb_wr ? paddr : cpu_reg_addr;
  wire [31:0] wd = apb_wr ? pwdata : cpu_reg_wdata;
  wire any_wr = apb_wr || cpu_reg_wr; // R21

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      OFS_CTRL: r = ctrl_q;
      OFS_STATUS: r = {26'h0, ovf_q, mem_busy_q, trace_on_q, inst_full_q, flow_q};
      OFS_INST: r = inst_q;
      OFS_OWNER: r = owner_q;
      OFS_MEM_ADDR: r = mem_addr_q;
      OFS_MEM_DATA: r = mem_data_q;
      default: begin
        for (int i = 0; i < NCMP; i++) begin
          if (a == OFS_CMP_BASE + 8'(12 * i)) r = cmp_addr_q[i];
          if (a == OFS_CMP_BASE + 8'(12 * i + 4)) r = cmp_val_q[i];
          if (a == OFS_CMP_BASE + 8'(12 * i + 8)) r = {24'h0, cmp_cfg_q[i]};
        end
      end
    endcase
    return r;
  endfunction : reg_read

  function automatic logic mapped(input logic [7:0] a);
    return (a < OFS_CMP_BASE + 8'(12 * NCMP)) && (a[1:0] == 2'b00) && (a != 8'h1c);
  endfunction : mapped

  // ==========================================================
  // Comparators on virtual addresses, chained pairwise
  logic [NCMP-1:0] raw_hit, hit;
  always_comb begin
    for (int i = 0; i < NCMP; i++) begin
      raw_hit[i] = cmp_cfg_q[i][CMP_EN] && flow_q == RUN && // R7
        (cmp_cfg_q[i][CMP_DATA_SIDE] ? (cpu_dacc && cpu_daddr == cmp_addr_q[i])
                                    : (cpu_fetch && cpu_pc == cmp_addr_q[i])) && // R6
        (!cmp_cfg_q[i][CMP_VAL_MATCH] || cpu_dvalue == cmp_val_q[i]);
    end
    for (int i = 0; i < NCMP; i++) begin
      hit[i] = raw_hit[i] && (i == 0 || !cmp_cfg_q[i][CMP_CHAIN] ||
        raw_hit[(i == 0) ? 0 : i - 1]); // R11
    end
  end

  logic brk_hit, watch_hit, start_tr, stop_tr;
  always_comb begin
    brk_hit = 1'b0;
    watch_hit = 1'b0;
    start_tr = 1'b0;
    stop_tr = 1'b0;
    for (int i = 0; i < NCMP; i++) begin
      if (hit[i] && (i == NCMP - 1 || !cmp_cfg_q[(i == NCMP - 1) ? i : i + 1][CMP_CHAIN])) begin
        if (cmp_cfg_q[i][CMP_BREAK]) brk_hit = 1'b1; // R8
        else watch_hit = 1'b1; // R9
        if (!cmp_cfg_q[i][CMP_BREAK] && cmp_cfg_q[i][CMP_TRACE_ON]) start_tr = 1'b1; // R10
        if (!cmp_cfg_q[i][CMP_BREAK] && cmp_cfg_q[i][CMP_TRACE_OFF]) stop_tr = 1'b1; // R10
      end
    end
  end

  // ==========================================================
  // Message sources; one per cycle by priority
  wire flow_chg = cpu_branch != BR_NONE; // R12
  wire ptr_ev = trace_on_q && ctrl_q[CTRL_PTRACE] && flow_q == RUN && flow_chg;
  wire dtr_ev = trace_on_q && flow_q == RUN && cpu_dacc &&
    (cpu_dwrite ? ctrl_q[CTRL_DTRACE_WR] : ctrl_q[CTRL_DTRACE_RD]); // R14
  wire owner_ev = any_wr && wa == OFS_OWNER; // R16
  wire sync_due = sync_cnt_q == '0;

  msg_if #(.W(MSG_W)) q_in ();
  logic [MSG_W-1:0] msg_d;
  logic msg_v;
  always_comb begin
    msg_v = 1'b1;
    msg_d = '0;
    if (err_pend_q) msg_d = {1'b0, MSG_ERROR, 36'h0}; // R15
    else if (sync_pend_q || (sync_due && (ptr_ev || dtr_ev)))
      msg_d = {1'b0, MSG_SYNC, 4'h0, ptr_ev ? cpu_target : cpu_daddr}; // R13
    else if (watch_hit) msg_d = {1'b0, MSG_WATCH, 4'h0, 28'h0, 4'(hit)}; // R9
    else if (owner_ev) msg_d = {1'b0, MSG_OWNER, 4'h0, wd}; // R16
    else if (ptr_ev) msg_d = {1'b0, MSG_BRANCH, 1'b0, cpu_branch, cpu_target - last_pc_q}; // R13
    else if (dtr_ev) msg_d = {1'b0, MSG_DATA, 3'h0, cpu_dwrite, cpu_daddr - last_da_q}; // R13
    else if (cpu_push) msg_d = {1'b0, MSG_MEM, 4'h0, cpu_push_data}; // R20
    else msg_v = 1'b0;
  end
  assign q_in.valid = msg_v; // R1
  assign q_in.data = msg_d;

  logic q_valid, q_take, q_ovf;
  logic [MSG_W-1:0] q_data;
  send_queue_mem #(.W(MSG_W), .DEPTH(DEPTH)) message_send_queue (
    .pclk(pclk),
    .presetn(presetn),
    .wr(q_in),
    .rd_take(q_take),
    .rd_valid(q_valid),
    .rd_data(q_data),
    .overflow(q_ovf)
  );

  aux_tx #(.W(MSG_W), .LANES(LANES)) aux_port (
    .pclk(pclk),
    .presetn(presetn),
    .msg_valid(q_valid),
    .msg_data(q_data),
    .msg_take(q_take),
    .aux_clk(aux_clk),
    .aux_data(aux_data),
    .aux_frame(aux_frame)
  );

  // ==========================================================
  // Debug flow controller
  wire enter_dbg = brk_hit || ctrl_q[CTRL_DBG_REQ]; // R8
  wire resume = any_wr && wa == OFS_CTRL && wd[CTRL_RESUME];
  wire inst_wr = any_wr && wa == OFS_INST;
  wire ext_mode = flow_q == DEBUG && !ctrl_q[CTRL_MONITOR];
  wire ovf_halt = ovf_q && ctrl_q[CTRL_HALT_OVF]; // R15

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_q <= RUN;
    end else begin
      case (flow_q)
        RUN: if (enter_dbg) flow_q <= DEBUG;
        DEBUG: if (cpu_retd || resume) flow_q <= ctrl_q[CTRL_STEP] ? STEP_RUN : RUN; // R5
        STEP_RUN: if (cpu_inst_taken) flow_q <= DEBUG; // R5
        default: flow_q <= RUN;
      endcase
    end
  end

  // ==========================================================
  // Registers and state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      owner_q <= '0;
      inst_q <= '0;
      inst_full_q <= 1'b0;
      mem_addr_q <= '0;
      mem_data_q <= '0;
      mem_busy_q <= 1'b0;
      mem_we_q <= 1'b0;
      trace_on_q <= 1'b0;
      ovf_q <= 1'b0;
      err_pend_q <= 1'b0;
      sync_pend_q <= 1'b0;
      last_pc_q <= '0;
      last_da_q <= '0;
      sync_cnt_q <= '0;
      for (int i = 0; i < NCMP; i++) begin
        cmp_addr_q[i] <= '0;
        cmp_val_q[i] <= '0;
        cmp_cfg_q[i] <= '0;
      end
    end else begin
      if (any_wr) begin
        case (wa)
          OFS_CTRL: ctrl_q <= wd & ~(32'h1 << CTRL_RESUME);
          OFS_OWNER: owner_q <= wd;
          OFS_MEM_ADDR: mem_addr_q <= wd;
          OFS_MEM_DATA: mem_data_q <= wd;
          default: begin
            for (int i = 0; i < NCMP; i++) begin
              if (wa == OFS_CMP_BASE + 8'(12 * i)) cmp_addr_q[i] <= wd;
              if (wa == OFS_CMP_BASE + 8'(12 * i + 4)) cmp_val_q[i] <= wd;
              if (wa == OFS_CMP_BASE + 8'(12 * i + 8)) cmp_cfg_q[i] <= wd[7:0];
            end
          end
        endcase
      end
      if (flow_q == RUN && enter_dbg) ctrl_q[CTRL_DBG_REQ] <= 1'b0;
      // Instruction register: set by write wins over fetch clear
      if (inst_wr) begin
        inst_q <= wd;
        inst_full_q <= 1'b1; // R2
      end else if (ext_mode && cpu_inst_taken) begin
        inst_full_q <= 1'b0; // R3
      end
      // Memory unit: physical address used as given
      if (any_wr && wa == OFS_MEM_CMD && wd[MEM_GO] && !mem_busy_q) begin
        mem_busy_q <= 1'b1; // R18
        mem_we_q <= wd[MEM_WRITE];
      end else if (mem_busy_q && mem_ack) begin
        mem_busy_q <= 1'b0;
        mem_addr_q <= mem_addr_q + 32'h4;
        if (!mem_we_q) mem_data_q <= mem_rdata;
      end
      // Trace enable by watchpoints
      if (start_tr) trace_on_q <= 1'b1; // R10
      else if (stop_tr) trace_on_q <= 1'b0;
      // Overflow handling
      if (q_ovf) begin
        ovf_q <= 1'b1;
        if (!ctrl_q[CTRL_HALT_OVF]) err_pend_q <= 1'b1; // R15
      end else if (any_wr && wa == OFS_STATUS) begin
        ovf_q <= 1'b0;
      end
      if (err_pend_q && q_in.ready) begin
        // A fresh overflow in the same cycle keeps the error pending
        err_pend_q <= q_ovf && !ctrl_q[CTRL_HALT_OVF];
        sync_pend_q <= 1'b1; // R15
      end else if (sync_pend_q && q_in.ready && !err_pend_q) begin
        sync_pend_q <= 1'b0;
      end
      if (ptr_ev) last_pc_q <= cpu_target; // R13
      if (dtr_ev) last_da_q <= cpu_daddr;
      if (ptr_ev || dtr_ev) sync_cnt_q <= sync_cnt_q + 1'b1; // R13
    end
  end

  // ==========================================================
  // Outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cpu_reg_rdata <= '0;
      cpu_halt <= 1'b0;
      cpu_debug <= 1'b0;
      cpu_fetch_dbg <= 1'b0;
      cpu_fetch_monitor <= 1'b0;
      dbg_inst <= '0;
      dbg_inst_valid <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_paddr <= '0;
      mem_wdata <= '0;
      event_out_pin <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      prdata <= (psel && !penable && !pwrite) ? reg_read(paddr) : 32'h0000_0000;
      cpu_reg_rdata <= reg_read(cpu_reg_addr); // R21
      cpu_debug <= flow_q == DEBUG;
      cpu_fetch_dbg <= ext_mode; // R2
      cpu_fetch_monitor <= flow_q == DEBUG && ctrl_q[CTRL_MONITOR]; // R4
      cpu_halt <= (ext_mode && !inst_full_q) || ovf_halt; // R3
      dbg_inst <= inst_q;
      dbg_inst_valid <= ext_mode && inst_full_q; // R4
      mem_req <= mem_busy_q && !mem_ack;
      mem_we <= mem_we_q;
      mem_paddr <= mem_addr_q; // R18
      mem_wdata <= mem_data_q;
      if (ctrl_q[CTRL_EVT_EN] && q_in.valid && q_in.ready)
        event_out_pin <= !event_out_pin; // R17
    end
  end
endmodule : debug_core

//--- rtl/dbg_pkg.sv
package dbg_pkg;

  // ==========================================================
  // Register offsets (APB byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INST = 8'h08;
  localparam logic [7:0] OFS_OWNER = 8'h0c;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h10;
  localparam logic [7:0] OFS_MEM_DATA = 8'h14;
  localparam logic [7:0] OFS_MEM_CMD = 8'h18;
  localparam logic [7:0] OFS_CMP_BASE = 8'h20;

  // ==========================================================
  // Control register fields
  localparam int CTRL_MONITOR = 0;
  localparam int CTRL_STEP = 1;
  localparam int CTRL_HALT_OVF = 2;
  localparam int CTRL_EVT_EN = 3;
  localparam int CTRL_PTRACE = 4;
  localparam int CTRL_DTRACE_RD = 5;
  localparam int CTRL_DTRACE_WR = 6;
  localparam int CTRL_DBG_REQ = 7;
  localparam int CTRL_RESUME = 8;

  // Comparator config fields
  localparam int CMP_EN = 0;
  localparam int CMP_DATA_SIDE = 1;
  localparam int CMP_VAL_MATCH = 2;
  localparam int CMP_BREAK = 3;
  localparam int CMP_TRACE_ON = 4;
  localparam int CMP_TRACE_OFF = 5;
  localparam int CMP_CHAIN = 6;

  // Memory command fields
  localparam int MEM_GO = 0;
  localparam int MEM_WRITE = 1;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int SYNC_PERIOD = 64;

  // ==========================================================
  // Message kinds
  typedef enum logic [2:0] {
    MSG_BRANCH, MSG_DATA, MSG_WATCH, MSG_OWNER, MSG_ERROR, MSG_SYNC, MSG_MEM
  } msg_kind_t;

  typedef enum logic [2:0] {
    BR_NONE, BR_UNCOND, BR_TAKEN, BR_IRQ, BR_EXC, BR_RET, BR_PC_LOAD
  } branch_kind_t;

  localparam int MSG_W = 40;

endpackage : dbg_pkg

//--- rtl/msg_if.sv
`timescale 1ns/1ps
interface msg_if #(parameter int W = 40);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : msg_if

//--- rtl/send_queue_mem.sv
`timescale 1ns/1ps
module send_queue_mem #(
  parameter int W = 40,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sides
  msg_if.dst wr,
  input wire logic rd_take,
  output logic rd_valid,
  output logic [W-1:0] rd_data,
  output logic overflow
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_q, rp_q;
  wire full = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  wire empty = (wp_q == rp_q);
  wire push = wr.valid && !full;
  wire pop = rd_take && rd_valid;
  assign wr.ready = !full;

  // ==========================================================
  // Strict order: single write pointer, single read pointer
  always_ff @(posedge pclk) begin // R23
    if (push) begin
      mem[wp_q[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= '0;
      rp_q <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      overflow <= 1'b0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      overflow <= wr.valid && full;
      if (!rd_valid || pop) begin
        rd_valid <= !empty;
        if (!empty) begin
          rd_data <= mem[rp_q[AW-1:0]]; // R23
          rp_q <= rp_q + 1'b1;
        end
      end
    end
  end
endmodule : send_queue_mem

//--- rtl/aux_tx.sv
`timescale 1ns/1ps
module aux_tx #(
  parameter int W = 40,
  parameter int LANES = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Message in
  input wire logic msg_valid,
  input wire logic [W-1:0] msg_data,
  output logic msg_take,
  // Link
  input wire logic aux_clk,
  output logic [LANES-1:0] aux_data,
  output logic aux_frame
);
  localparam int BEATS = (W + LANES - 1) / LANES;
  logic clk_s1_q, clk_s2_q, clk_s3_q;
  logic [W-1:0] sh_q;
  logic [$clog2(BEATS+1)-1:0] cnt_q;
  wire fall = clk_s3_q && !clk_s2_q;

  // ==========================================================
  // Shift a message out lane by lane on each link clock fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      sh_q <= '0;
      cnt_q <= '0;
      aux_data <= '0;
      aux_frame <= 1'b0;
      msg_take <= 1'b0;
    end else begin
      clk_s1_q <= aux_clk;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      msg_take <= 1'b0;
      if (fall) begin
        if (cnt_q != '0) begin
          aux_data <= sh_q[LANES-1:0];
          sh_q <= sh_q >> LANES;
          cnt_q <= cnt_q - 1'b1;
          aux_frame <= 1'b1;
        end else if (msg_valid && !msg_take) begin
          aux_data <= msg_data[LANES-1:0];
          sh_q <= msg_data >> LANES;
          cnt_q <= ($bits(cnt_q))'(BEATS - 1);
          aux_frame <= 1'b1;
          msg_take <= 1'b1;
        end else begin
          aux_frame <= 1'b0;
          aux_data <= '0;
        end
      end
    end
  end
endmodule : aux_tx

//--- bench/debug_core_chk.sv
`timescale 1ns/1ps
module debug_core_chk
  import dbg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // CPU and memory
  input wire logic cpu_halt,
  input wire logic cpu_fetch_dbg,
  input wire logic cpu_fetch_monitor,
  input wire logic dbg_inst_valid,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_paddr,
  // Link
  input wire logic aux_frame
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("answer outside access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("answer held too long");
  refuse_zero_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("refused read not zero");
  resume_reads_a: assert property (pready && !pwrite && paddr == OFS_CTRL |-> !prdata[8])
    else $error("resume bit reads set");
  fetch_excl_a: assert property (cpu_fetch_dbg |-> !cpu_fetch_monitor)
    else $error("both fetch sources on");
  empty_halt_a: assert property (cpu_fetch_dbg && !dbg_inst_valid |-> ##[0:1] cpu_halt)
    else $error("running with empty register");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_paddr))
    else $error("memory request dropped");
  frame_len_a: assert property ($rose(aux_frame) |-> aux_frame [*8])
    else $error("frame too short");
endmodule : debug_core_chk

//--- bench/emulator_model.sv
`timescale 1ns/1ps
module emulator_model #(
  parameter int MEM_WAIT = 2
) (
  // Clock
  input wire logic pclk,
  // Aux link
  output logic aux_clk,
  input wire logic [3:0] aux_data,
  input wire logic aux_frame,
  // Memory side
  input wire logic mem_req,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [39:0] msgs [0:15];
  logic [39:0] sh;
  int n_msg = 0;
  int beat = 0;
  int wait_n = 0;
  initial begin
    aux_clk = 1'b0;
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
  end
  // Link clock runs free so the sender can pace its beats
  always #40 aux_clk = ~aux_clk;
  // Beats arrive lowest nibble first, ten to a message
  always @(negedge aux_clk) begin
    if (aux_frame === 1'b1) begin
      sh[4*beat +: 4] = aux_data;
      beat = beat + 1;
      if (beat == 10) begin
        msgs[n_msg % 16] = sh;
        n_msg = n_msg + 1;
        beat = 0;
      end
    end else begin
      beat = 0;
    end
  end
  // Memory answers after a few waits; idle data keeps moving
  always @(posedge pclk) begin
    mem_ack <= 1'b0;
    if (mem_req === 1'b1 && !mem_ack) begin
      wait_n <= wait_n + 1;
      if (wait_n == MEM_WAIT) begin
        mem_ack <= 1'b1;
        wait_n <= 0;
      end
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : emulator_model

//--- bench/on_chip_debug_control_tb_top.sv
`timescale 1ns/1ps
module on_chip_debug_control_tb_top;
  import dbg_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpu_reg_wr = 1'b0, cpu_fetch = 1'b0;
  logic cpu_dacc = 1'b0, cpu_dwrite = 1'b0, cpu_retd = 1'b0, cpu_inst_taken = 1'b0;
  logic cpu_push = 1'b0;
  logic [7:0] paddr = '0, cpu_reg_addr = '0;
  logic [31:0] pwdata = '0, cpu_reg_wdata = '0, cpu_pc = '0, cpu_target = '0;
  logic [31:0] cpu_daddr = '0, cpu_dvalue = '0, cpu_push_data = '0;
  branch_kind_t cpu_branch = BR_NONE;
  logic [31:0] prdata, cpu_reg_rdata, dbg_inst, mem_paddr, mem_wdata, mem_rdata, rv;
  logic pready, pslverr, cpu_halt, cpu_debug, cpu_fetch_dbg, cpu_fetch_monitor, ev;
  logic dbg_inst_valid, mem_req, mem_we, mem_ack, aux_frame, event_out_pin, aux_clk;
  logic [3:0] aux_data;
  int n_fail = 0;
  int checks_done = 0;
  int n_evt = 0;
  int cyc = 0;
  int n;
  msg_kind_t kinds [5] = '{MSG_WATCH, MSG_SYNC, MSG_OWNER, MSG_OWNER, MSG_MEM};

  always #5 pclk = ~pclk;
  always @(event_out_pin) if (presetn) n_evt++;

  debug_core #(.NCMP(4), .DEPTH(16), .LANES(4)) DUT (.*);
  emulator_model #(.MEM_WAIT(2)) u_emu (.*);

  // ==========================================================
  // Bus and check helpers
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic tick(input int k);
    repeat (k) @(negedge pclk);
  endtask : tick

  task automatic flow(input logic [1:0] f);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("flow", {30'h0, rv[1:0]}, {30'h0, f});
  endtask : flow

  task automatic fetch(input logic [31:0] pc, input branch_kind_t b);
    @(posedge pclk);
    cpu_fetch <= 1'b1;
    cpu_pc <= pc;
    cpu_branch <= b;
    @(posedge pclk);
    cpu_fetch <= 1'b0;
    cpu_branch <= BR_NONE;
    tick(3);
  endtask : fetch

  task automatic dacc(input logic [31:0] v);
    @(posedge pclk);
    cpu_dacc <= 1'b1;
    cpu_daddr <= 32'h3000;
    cpu_dvalue <= v;
    @(posedge pclk);
    cpu_dacc <= 1'b0;
    tick(3);
  endtask : dacc

  task automatic retd();
    @(posedge pclk);
    cpu_retd <= 1'b1;
    @(posedge pclk);
    cpu_retd <= 1'b0;
    tick(3);
  endtask : retd

  task automatic tally_and_finish();
    $display("TB: checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rv, CTRL_RESET);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", rv, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk("refused", {ev, rv[30:0]}, 32'h8000_0000);
    apb(1'b1, OFS_CTRL, 32'h80);
    tick(3);
    chk("halt", {cpu_debug, cpu_fetch_dbg, cpu_halt}, 32'h7);
    apb(1'b1, OFS_INST, 32'habcd_0123);
    tick(2);
    chk("inst", dbg_inst, 32'habcd_0123);
    chk("run", {dbg_inst_valid, cpu_halt}, 32'h2);
    @(posedge pclk);
    cpu_inst_taken <= 1'b1;
    @(posedge pclk);
    cpu_inst_taken <= 1'b0;
    tick(3);
    chk("halt", cpu_halt, 1'b1);
    retd();
    flow(2'h0);
    apb(1'b1, OFS_CTRL, 32'h81);
    tick(3);
    apb(1'b1, OFS_INST, 32'h1111);
    tick(2);
    chk("monitor", {cpu_fetch_monitor, cpu_fetch_dbg}, 32'h2);
    apb(1'b1, OFS_CTRL, 32'h101);
    tick(3);
    flow(2'h0);
    apb(1'b1, OFS_CTRL, 32'h82);
    tick(3);
    apb(1'b1, OFS_CTRL, 32'h102);
    tick(6);
    flow(2'h2);
    chk("step", cpu_debug, 1'b0);
    @(posedge pclk);
    cpu_inst_taken <= 1'b1;
    @(posedge pclk);
    cpu_inst_taken <= 1'b0;
    tick(3);
    flow(2'h1);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h100);
    tick(3);
    apb(1'b1, OFS_CMP_BASE, 32'h1000);
    apb(1'b1, OFS_CMP_BASE + 8'h08, 32'h09);
    fetch(32'h1004, BR_NONE);
    chk("miss", cpu_debug, 1'b0);
    fetch(32'h1000, BR_NONE);
    chk("break", cpu_debug, 1'b1);
    retd();
    apb(1'b1, OFS_CMP_BASE + 8'h0c, 32'h3000);
    apb(1'b1, OFS_CMP_BASE + 8'h10, 32'h77);
    apb(1'b1, OFS_CMP_BASE + 8'h14, 32'h0f);
    dacc(32'h76);
    chk("value miss", cpu_debug, 1'b0);
    dacc(32'h77);
    chk("value hit", cpu_debug, 1'b1);
    retd();
    flow(2'h0);
    apb(1'b1, OFS_CMP_BASE + 8'h14, 32'h0);
    apb(1'b1, OFS_CMP_BASE + 8'h08, 32'h11);
    apb(1'b1, OFS_CTRL, 32'h18);
    fetch(32'h1000, BR_NONE);
    chk("watch run", cpu_debug, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("trace on", rv[3], 1'b1);
    fetch(32'h1010, BR_TAKEN);
    fetch(32'h1014, BR_NONE);
    @(posedge pclk);
    cpu_reg_wr <= 1'b1;
    cpu_reg_addr <= OFS_OWNER;
    cpu_reg_wdata <= 32'h2a;
    @(posedge pclk);
    cpu_reg_wr <= 1'b0;
    cpu_reg_addr <= OFS_CTRL;
    apb(1'b1, OFS_OWNER, 32'h2b);
    @(posedge pclk);
    cpu_push <= 1'b1;
    cpu_push_data <= 32'h5a5a_0001;
    @(posedge pclk);
    cpu_push <= 1'b0;
    tick(2);
    chk("cpu read", cpu_reg_rdata, 32'h18);
    n = 0;
    while (u_emu.n_msg < 5 && n < 3000) begin
      tick(1);
      n++;
    end
    tick(300);
    chk("messages", u_emu.n_msg, 5);
    for (int i = 0; i < 5; i++) begin
      chk("kind", u_emu.msgs[i][38:36], kinds[i]);
    end
    chk("events", n_evt, 5);
    apb(1'b1, OFS_MEM_ADDR, 32'h2000);
    apb(1'b1, OFS_MEM_DATA, 32'h1234_5678);
    apb(1'b1, OFS_MEM_CMD, 32'h3);
    n = 0;
    while (mem_req !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk("mem addr", mem_paddr, 32'h2000);
    chk("mem data", {mem_we, mem_wdata[30:0]}, 32'h9234_5678);
    tick(10);
    apb(1'b0, OFS_MEM_ADDR, 32'h0);
    chk("next addr", rv, 32'h2004);
    apb(1'b1, OFS_CTRL, 32'h40);
    dacc(32'h0);
    @(posedge pclk);
    cpu_dwrite <= 1'b1;
    dacc(32'h0);
    tick(200);
    chk("data count", u_emu.n_msg, 6);
    chk("data kind", u_emu.msgs[5][38:36], MSG_DATA);
    apb(1'b1, OFS_CTRL, 32'h04);
    @(posedge pclk);
    cpu_push <= 1'b1;
    repeat (20) @(posedge pclk);
    cpu_push <= 1'b0;
    tick(2);
    chk("ovf halt", cpu_halt, 1'b1);
    tally_and_finish();
  end
endmodule : on_chip_debug_control_tb_top

bind debug_core debug_core_chk u_chk (.*);
